// file: include/csr_consts.svh
// Constants for the charge setpoint and status register bank.
// Assumes a 250 MHz ref_clk and a word-wide register port behind the SMBus engine.
`ifndef CSR_CONSTS_SVH
`define CSR_CONSTS_SVH

// ****************************************************************
// Register command codes
// ****************************************************************
`define CSR_ADDR_CURRENT      8'h14
`define CSR_ADDR_VOLTAGE      8'h15
`define CSR_ADDR_STATUS       8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define CSR_CUR_MSB           12
`define CSR_CUR_LSB           6
`define CSR_VOLT_MSB          14
`define CSR_VOLT_LSB          3
`define CSR_VOLT_RSVD_BIT     15
`define CSR_STAT_WR_MASK      16'h0018

// ****************************************************************
// Limits, reset values and masks; voltage codes in mV units, current codes in mA units
// ****************************************************************
`define CSR_VOLT_MIN          16'h0400
`define CSR_VOLT_MAX          16'h4B00
`define CSR_VOLT_1S           16'h1068
`define CSR_VOLT_2S           16'h20D0
`define CSR_VOLT_3S           16'h3138
`define CSR_VOLT_4S           16'h41A0
`define CSR_STATUS_RESET      16'h0000
`define CSR_PRECHG_CLAMP      16'h0180
`define CSR_FAST_1S_CLAMP     16'h07C0
`define CSR_CUR_FIELD_MASK    16'h1FC0
`define CSR_VOLT_FIELD_MASK   16'h7FF8

`endif

// file: include/csr_pkg.sv
// Types for the charge setpoint and status register bank.
// Assumes csr_consts.svh is on the include path.
package csr_pkg;

  // ****************************************************************
  // Charge phase
  // ****************************************************************
  typedef enum logic [2:0] {
    CSR_IDLE    = 3'b001,
    CSR_PRECHG  = 3'b010,
    CSR_FASTCHG = 3'b100
  } csr_phase_t;

  // ****************************************************************
  // Status inputs from the analog side
  // ****************************************************************
  typedef struct packed {
    logic input_present;
    logic optimizer_done;
    logic vmin_assist_active;
    logic input_voltage_limiting;
    logic input_current_limiting;
    logic fast_charge_active;
    logic precharge_active;
    logic reverse_power_active;
  } csr_state_t;

  typedef struct packed {
    logic input_overvoltage_fault;
    logic battery_overcurrent_fault;
    logic input_overcurrent_fault;
    logic system_overvoltage_fault;
    logic system_undervoltage_fault;
    logic converter_off_fault;
    logic reverse_overvoltage_fault;
    logic reverse_undervoltage_fault;
  } csr_fault_t;

  // Word-wide register access from the SMBus engine
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  cmd;
    logic [15:0] wdata;
  } csr_req_t;

endpackage : csr_pkg

// file: src/csr_precharge_clamp.sv
// Pre-charge and fast-charge current clamp for the charge setpoint bank.
// Assumes battery comparator levels are already synchronous to ref_clk.
`include "csr_consts.svh"

module csr_precharge_clamp
  import csr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        charging,
  input  wire logic        one_cell,
  input  wire logic        batt_below_vmin,
  input  wire logic        batt_below_3v,
  input  wire logic        linear_precharge_enable,
  input  wire logic [15:0] current_setpoint,
  output      logic [15:0] current_target,
  output      logic        battery_switch_linear,
  output      csr_phase_t  phase
);

  logic [15:0] next_current_target;
  logic        next_battery_switch_linear;
  csr_phase_t  next_phase;
  logic        in_precharge;

  // ****************************************************************
  // Phase and clamp
  // ****************************************************************
  always_comb begin
    in_precharge = one_cell ? batt_below_3v : batt_below_vmin;
    next_phase   = CSR_IDLE;
    if (charging) begin
      next_phase = in_precharge ? CSR_PRECHG : CSR_FASTCHG;
    end
    next_current_target        = charging ? current_setpoint : 16'h0000;
    next_battery_switch_linear = 1'b0;
    if (charging && linear_precharge_enable && batt_below_vmin) begin
      next_battery_switch_linear = 1'b1;
    end
    if (charging && linear_precharge_enable) begin
      if (in_precharge && current_setpoint > `CSR_PRECHG_CLAMP) begin
        next_current_target = `CSR_PRECHG_CLAMP;
      end else if (one_cell && batt_below_vmin
                   && current_setpoint > `CSR_FAST_1S_CLAMP) begin
        next_current_target = `CSR_FAST_1S_CLAMP;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      current_target        <= 16'h0000;
      battery_switch_linear <= 1'b0;
      phase                 <= CSR_IDLE;
    end else begin
      current_target        <= next_current_target;
      battery_switch_linear <= next_battery_switch_linear;
      phase                 <= next_phase;
    end
  end

endmodule : csr_precharge_clamp

// file: src/csr_charge_regs.sv
// Charge current, charge voltage and charger status registers.
// Assumes an SMBus engine delivers whole words (low byte first on the wire)
// as one-cycle requests, and that analog status levels are ref_clk synchronous.
//
// Summary of operation
// - Bits 7 and 6 weigh 128, 64 mA
// - Reserved current bits and voltage bits 2..0 do nothing
// - Voltage write with bit 15 set rejected
// - Voltage bits 14..3 in 8 mV steps
// - Only 1.024 V to 19.200 V accepted
// - Reset voltage from cell-count strap
// - Current write starts charge when power good
// - Zero voltage write clears current, keeps voltage
// - Linear pre-charge uses switch in linear mode
// - Multi-cell pre-charge clamped to 384 mA; clamp applies only with linear_precharge_enable set
// - One cell: 3 V threshold, linear until vmin
// - One cell below vmin: fast charge 1984 mA; clamp applies only with linear_precharge_enable set
// - Status at 20h, upper byte live states
// - Lower byte latched faults, bits 4,3 writable
// - Bits 12..8 weigh 4096 down to 256 mA
// - Clear current on removal, reset, watchdog
// - Input present follows valid input window
`include "csr_consts.svh"

module csr_charge_regs
  import csr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire csr_req_t    req,
  output      logic [15:0] rdata,
  output      logic        rvalid,
  output      logic        wr_invalid,
  input  wire logic [1:0]  cell_count_strap,
  input  wire logic        battery_present,
  input  wire logic        input_power_good,
  input  wire logic        watchdog_event,
  input  wire logic        register_reset,
  input  wire logic        linear_precharge_enable,
  input  wire logic        batt_below_vmin,
  input  wire logic        batt_below_3v,
  input  wire csr_state_t  live_state,
  input  wire csr_fault_t  fault_event,
  output      logic [15:0] current_target,
  output      logic [15:0] voltage_target,
  output      logic        charge_enable,
  output      logic        battery_switch_linear,
  output      csr_phase_t  phase
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0] current_setpoint;
  logic [15:0] next_current_setpoint;
  logic [15:0] voltage_setpoint;
  logic [15:0] next_voltage_setpoint;
  logic [7:0]  status_hi;
  logic [7:0]  next_status_hi;
  logic [7:0]  fault_flags;
  logic [7:0]  next_fault_flags;
  logic [15:0] next_rdata;
  logic        next_rvalid;
  logic        next_wr_invalid;
  logic        next_charge_enable;
  logic        strap_loaded;
  logic [15:0] strap_voltage;
  logic [15:0] volt_code;
  logic        cur_write;
  logic        volt_write;
  logic        stat_write;
  logic        clear_current;

  // ****************************************************************
  // Request decode
  // ****************************************************************
  assign cur_write     = req.wr && (req.cmd == `CSR_ADDR_CURRENT);
  assign volt_write    = req.wr && (req.cmd == `CSR_ADDR_VOLTAGE);
  assign stat_write    = req.wr && (req.cmd == `CSR_ADDR_STATUS);
  // Any of these drops the charge current back to zero
  assign clear_current = !battery_present || !live_state.input_present
                         || register_reset || watchdog_event;
  assign volt_code     = req.wdata & `CSR_VOLT_FIELD_MASK;

  // ****************************************************************
  // Strap decode
  // ****************************************************************
  always_comb begin
    unique case (cell_count_strap)
      2'd0:    strap_voltage = `CSR_VOLT_1S;
      2'd1:    strap_voltage = `CSR_VOLT_2S;
      2'd2:    strap_voltage = `CSR_VOLT_3S;
      default: strap_voltage = `CSR_VOLT_4S;
    endcase
  end

  // ****************************************************************
  // Setpoint registers
  // ****************************************************************
  always_comb begin
    next_current_setpoint = current_setpoint;
    next_voltage_setpoint = voltage_setpoint;
    next_wr_invalid       = 1'b0;
    // Strap is taken once after reset and again on register reset
    if (!strap_loaded) begin
      next_voltage_setpoint = strap_voltage;
    end
    if (cur_write) begin
      // Reserved bits are dropped here, so they read back as zero
      next_current_setpoint = req.wdata & `CSR_CUR_FIELD_MASK;
    end
    if (volt_write) begin
      if (req.wdata[`CSR_VOLT_RSVD_BIT]) begin
        next_wr_invalid = 1'b1;
      end else if (volt_code == 16'h0000) begin
        // Code zero stops charging and is never stored as a voltage
        next_current_setpoint = 16'h0000;
      end else if (volt_code < `CSR_VOLT_MIN || volt_code > `CSR_VOLT_MAX) begin
        next_wr_invalid = 1'b1;
      end else begin
        next_voltage_setpoint = volt_code;
      end
    end
    if (clear_current) begin
      next_current_setpoint = 16'h0000;
    end
    if (register_reset) begin
      next_voltage_setpoint = strap_voltage;
    end
    // Charge runs with whatever voltage is held, strap default included
    next_charge_enable = input_power_good && (next_current_setpoint != 16'h0000);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      current_setpoint <= 16'h0000;
      voltage_setpoint <= `CSR_VOLT_1S;
      strap_loaded     <= 1'b0;
      wr_invalid       <= 1'b0;
      charge_enable    <= 1'b0;
    end else begin
      current_setpoint <= next_current_setpoint;
      voltage_setpoint <= next_voltage_setpoint;
      strap_loaded     <= 1'b1;
      wr_invalid       <= next_wr_invalid;
      charge_enable    <= next_charge_enable;
    end
  end

  // ****************************************************************
  // Status register
  // ****************************************************************
  always_comb begin
    // Live states follow their inputs one cycle late
    next_status_hi   = live_state;
    next_fault_flags = fault_flags;
    if (stat_write) begin
      next_fault_flags = (fault_flags & ~8'(`CSR_STAT_WR_MASK))
                         | (req.wdata[7:0] & 8'(`CSR_STAT_WR_MASK));
    end
    // A fault event in the same cycle as a clearing write wins
    next_fault_flags = next_fault_flags | fault_event;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_hi   <= 8'(`CSR_STATUS_RESET >> 8);
      fault_flags <= 8'(`CSR_STATUS_RESET);
    end else begin
      status_hi   <= next_status_hi;
      fault_flags <= next_fault_flags;
    end
  end

  // ****************************************************************
  // Read port, one word per request
  // ****************************************************************
  always_comb begin
    // Unmapped commands read as zero
    next_rvalid = req.rd;
    next_rdata  = 16'h0000;
    if (req.rd) begin
      unique case (req.cmd)
        `CSR_ADDR_CURRENT: next_rdata = current_setpoint;
        `CSR_ADDR_VOLTAGE: next_rdata = voltage_setpoint;
        `CSR_ADDR_STATUS:  next_rdata = {status_hi, fault_flags};
        default:           next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata          <= 16'h0000;
      rvalid         <= 1'b0;
      voltage_target <= 16'h0000;
    end else begin
      rdata          <= next_rdata;
      rvalid         <= next_rvalid;
      // Target voltage trails the stored setpoint by one cycle
      voltage_target <= voltage_setpoint;
    end
  end

  // ****************************************************************
  // Current clamp
  // ****************************************************************
  // Clamp registers the setpoint, so targets trail a write by two cycles
  csr_precharge_clamp u_clamp (
    .ref_clk                 (ref_clk),
    .rst_n                   (rst_n),
    .charging                (charge_enable),
    .one_cell                (cell_count_strap == 2'd0),
    .batt_below_vmin         (batt_below_vmin),
    .batt_below_3v           (batt_below_3v),
    .linear_precharge_enable (linear_precharge_enable),
    .current_setpoint        (current_setpoint),
    .current_target          (current_target),
    .battery_switch_linear   (battery_switch_linear),
    .phase                   (phase)
  );

endmodule : csr_charge_regs

// file: tb/csr_charge_regs_assertions.sv
// Port checker for the charge register bank.
// Bound to csr_charge_regs; sees only its ports.
module csr_charge_regs_checker
  import csr_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire csr_req_t    req,
  input wire logic [15:0] rdata,
  input wire logic        rvalid,
  input wire logic        wr_invalid,
  input wire logic        input_power_good,
  input wire logic        linear_precharge_enable,
  input wire csr_fault_t  fault_event,
  input wire logic [15:0] current_target,
  input wire logic [15:0] voltage_target,
  input wire logic        charge_enable,
  input wire csr_phase_t  phase
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        vwr;
  logic [15:0] vm;
  assign vwr = req.wr && req.cmd == 8'h15;
  assign vm  = req.wdata & 16'h7FF8;
  default clocking ck @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  rd_answer_a: assert property (req.rd |=> rvalid)
    else $error("read not answered");
  top_bit_a: assert property (vwr && req.wdata[15] |=> wr_invalid)
    else $error("bit 15 write accepted");
  volt_range_a: assert property (vwr && !req.wdata[15] && vm != 0 &&
    (vm < 16'h0400 || vm > 16'h4B00) |=> wr_invalid) else $error("range not refused");
  zero_volt_a: assert property (vwr && req.wdata == 0 |=> !wr_invalid ##1
    current_target == 0) else $error("zero voltage kept current");
  volt_legal_a: assert property (voltage_target != 0 |-> voltage_target[2:0] == 0 &&
    voltage_target >= 16'h0400 && voltage_target <= 16'h4B00) else $error("bad voltage");
  cur_rsvd_a: assert property (current_target[5:0] == 0 && current_target[15:13] == 0)
    else $error("reserved current bits");
  pre_clamp_a: assert property (phase == CSR_PRECHG && $past(linear_precharge_enable)
    |-> current_target <= 16'h0180) else $error("precharge clamp");
  pg_gate_a: assert property (!input_power_good [*2] |-> !charge_enable)
    else $error("charge without power good");
  fault_latch_a: assert property (fault_event[7] ##2 (req.rd && req.cmd == 8'h20)
    |=> rdata[7]) else $error("fault not latched");
endmodule : csr_charge_regs_checker
bind csr_charge_regs csr_charge_regs_checker i_chk (.ref_clk, .rst_n, .req, .rdata, .rvalid,
  .wr_invalid, .input_power_good, .linear_precharge_enable, .fault_event, .current_target,
  .voltage_target, .charge_enable, .phase);

// file: tb/csr_host_model.sv
// Host controller model issuing whole-word register requests.
// Assumes byte pairing of the SMBus words happens in front of the bank.
module csr_host_model
  import csr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rvalid,
  input  wire logic [15:0] rdata,
  output      csr_req_t    req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req = '0;
  // Request held through the edge that takes it
  task automatic put(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge ref_clk);
    #1 req = '{w, !w, c, d};
    @(posedge ref_clk);
    #1 req = '0;
  endtask : put
  task automatic get(input logic [7:0] c, output logic [15:0] d, output logic ok);
    put(1'b0, c, 16'h0000);
    ok = rvalid;
    d = rdata;
  endtask : get
endmodule : csr_host_model

// file: tb/test_charge_setpoint_status_regs.sv
// Self-checking bench for the charge register bank.
// Drives requests through the host model; the checker is bound.
module test_charge_setpoint_status_regs
  import csr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] wd;
    logic [15:0] ex;
    logic        inv;
  } csr_row_t;
  localparam csr_row_t rows [11] = '{
    '{8'h14, 16'hFFFF, 16'h1FC0, 1'b0}, '{8'h14, 16'h00C0, 16'h00C0, 1'b0},
    '{8'h15, 16'h1077, 16'h1070, 1'b0}, '{8'h15, 16'hA000, 16'h1070, 1'b1},
    '{8'h15, 16'h03FF, 16'h1070, 1'b1}, '{8'h15, 16'h0400, 16'h0400, 1'b0},
    '{8'h15, 16'h4B08, 16'h0400, 1'b1}, '{8'h15, 16'h4B00, 16'h4B00, 1'b0},
    '{8'h20, 16'hFFFF, 16'h8018, 1'b0}, '{8'h20, 16'h0000, 16'h8000, 1'b0},
    '{8'h99, 16'h1234, 16'h0000, 1'b0}};
  localparam logic [15:0] vdef [4] = '{16'h1068, 16'h20D0, 16'h3138, 16'h41A0};
  logic        ref_clk, rst_n, rvalid, wr_invalid, charge_enable, battery_switch_linear;
  logic        battery_present, input_power_good, watchdog_event, register_reset;
  logic        linear_precharge_enable, batt_below_vmin, batt_below_3v;
  logic [1:0]  cell_count_strap;
  logic [15:0] rdata, current_target, voltage_target;
  csr_req_t    req;
  csr_state_t  live_state;
  csr_fault_t  fault_event;
  csr_phase_t  phase;
  int          error_cnt = 0;
  int          comparisons = 0;
  csr_charge_regs i_dut (.ref_clk, .rst_n, .req, .rdata, .rvalid, .wr_invalid, .cell_count_strap,
    .battery_present, .input_power_good, .watchdog_event, .register_reset,
    .linear_precharge_enable, .batt_below_vmin, .batt_below_3v, .live_state, .fault_event,
    .current_target, .voltage_target, .charge_enable, .battery_switch_linear, .phase);
  csr_host_model i_host (.ref_clk, .rvalid, .rdata, .req);
  task automatic finish_test;
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] got, input logic [15:0] ex);
    comparisons++;
    if (got !== ex) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask : chk
  task automatic rd(input logic [7:0] c, input logic [15:0] ex);
    logic [15:0] d;
    logic        ok;
    i_host.get(c, d, ok);
    chk(16'(ok), 16'h0001);
    if (ok !== 1'b1) begin
      finish_test();
    end else begin
      chk(d, ex);
    end
  endtask : rd
  // Two edges: the setpoint path latency
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    {rst_n, battery_present, input_power_good, watchdog_event, register_reset} = '0;
    {batt_below_vmin, batt_below_3v, live_state, fault_event} = '0;
    linear_precharge_enable = 1'b1;
    for (int s = 0; s < 4; s++) begin
      cell_count_strap = 2'(s);
      rst_n = 1'b0;
      repeat (s == 0 ? 20 : 2) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      rd(8'h15, vdef[s]);
      rd(8'h20, 16'h0000);
      rd(8'h14, 16'h0000);
    end
    battery_present = 1'b1;
    live_state = 8'h80;
    foreach (rows[i]) begin
      i_host.put(1'b1, rows[i].cmd, rows[i].wd);
      chk(16'(wr_invalid), 16'(rows[i].inv));
      rd(rows[i].cmd, rows[i].ex);
    end
    input_power_good = 1'b1;
    i_host.put(1'b1, 8'h14, 16'h0800);
    settle();
    chk(16'(charge_enable), 16'h0001);
    chk(current_target, 16'h0800);
    batt_below_vmin = 1'b1;
    settle();
    chk(current_target, 16'h0180);
    chk(16'(battery_switch_linear), 16'h0001);
    i_host.put(1'b1, 8'h15, 16'h0000);
    chk(16'(wr_invalid), 16'h0000);
    rd(8'h15, 16'h4B00);
    chk(voltage_target, 16'h4B00);
    rd(8'h14, 16'h0000);
    chk(16'(charge_enable), 16'h0000);
    @(posedge ref_clk);
    #1 fault_event = 8'h80;
    @(posedge ref_clk);
    #1 fault_event = 8'h00;
    rd(8'h20, 16'h8080);
    i_host.put(1'b1, 8'h20, 16'h0000);
    rd(8'h20, 16'h8080);
    live_state = 8'hA5;
    rd(8'h20, 16'hA580);
    live_state = 8'h80;
    i_host.put(1'b1, 8'h14, 16'h0100);
    #4 battery_present = 1'b0;
    #4 battery_present = 1'b1;
    rd(8'h14, 16'h0000);
    i_host.put(1'b1, 8'h14, 16'h0100);
    @(posedge ref_clk);
    #1 watchdog_event = 1'b1;
    @(posedge ref_clk);
    #1 watchdog_event = 1'b0;
    rd(8'h14, 16'h0000);
    i_host.put(1'b1, 8'h14, 16'h0100);
    @(posedge ref_clk);
    #1 register_reset = 1'b1;
    @(posedge ref_clk);
    #1 register_reset = 1'b0;
    rd(8'h14, 16'h0000);
    rd(8'h15, 16'h41A0);
    cell_count_strap = 2'b00;
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    i_host.put(1'b1, 8'h14, 16'h0800);
    settle();
    chk(current_target, 16'h07C0);
    batt_below_3v = 1'b1;
    settle();
    chk(current_target, 16'h0180);
    chk(16'(phase), 16'(CSR_PRECHG));
    linear_precharge_enable = 1'b0;
    settle();
    chk(current_target, 16'h0800);
    chk(16'(battery_switch_linear), 16'h0000);
    finish_test();
  end
endmodule : test_charge_setpoint_status_regs
